// >>> core/stc_commutator.sv
`timescale 1ns/100ps
`default_nettype none

module stc_commutator
    import stc_pkg::*;
#(
    parameter logic [CNT_W-1:0] ALIGN_STEP_PERIODS = ALIGN_STEP_RST,
    parameter logic [CNT_W-1:0] OL_START_INTERVAL  = OL_START_RST
)
(
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic [7:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    input  wire logic [3:0]       avs_byteenable,
    output logic      [31:0]      avs_readdata,
    output logic                  avs_waitrequest,
    input  wire logic             overcurrent_fault_input,
    input  wire logic [ADC_W-1:0] adc_phase_a,
    input  wire logic [ADC_W-1:0] adc_phase_b,
    input  wire logic [ADC_W-1:0] adc_phase_c,
    input  wire logic [ADC_W-1:0] adc_bus,
    input  wire logic             adc_valid,
    output logic                  sample_req,
    output logic      [2:0]       gate_hi,
    output logic      [2:0]       gate_lo,
    output logic                  irq
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        stc_mode_t        mode;
        logic [2:0]       step;
        logic [2:0]       gate_hi;
        logic [2:0]       gate_lo;
        logic [CNT_W-1:0] duty;
        logic [PCT_W-1:0] align_pct;
        logic [CNT_W-1:0] align_cnt;
        logic [CNT_W-1:0] ol_interval;
        logic [CNT_W-1:0] ol_cnt;
        logic [ACC_W-1:0] acc;
        logic             integrating;
        logic             run;
        logic [CNT_W-1:0] period;
        logic [CNT_W-1:0] duty_cmd;
        logic [CNT_W-1:0] ceiling;
        logic [CNT_W-1:0] floor_lvl;
        logic [ACC_W-1:0] flux;
        logic [CNT_W-1:0] ol_top;
        logic [PCT_W-1:0] start_max;
        logic [ST_W-1:0]  status;
        logic [ST_W-1:0]  mask;
        logic             irq;
        logic             fault_d;
        logic             waitreq;
        logic [31:0]      readdata;
        logic             sample_req;
    } stc_state_t;

    stc_state_t s_reg;
    stc_state_t s_next;

    logic             fault_level;
    logic [CNT_W-1:0] pwm_count;
    logic             pwm_tick;
    logic             pwm_start;

    stc_sync3 u_fault_sync (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .pin_in    (overcurrent_fault_input),
        .level_out (fault_level)
    );

    stc_pwm_timer u_timer (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .period       (s_reg.period),
        .count        (pwm_count),
        .tick         (pwm_tick),
        .period_start (pwm_start)
    );

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // leg indices 0=a 1=b 2=c; step order a+b-, a+c-, b+c-, b+a-, c+a-, c+b-
    function automatic logic [1:0] hi_leg(input logic [2:0] st);
        case (st)
            3'd0, 3'd1: hi_leg = 2'd0;
            3'd2, 3'd3: hi_leg = 2'd1;
            default:    hi_leg = 2'd2;
        endcase
    endfunction

    function automatic logic [1:0] lo_leg(input logic [2:0] st);
        case (st)
            3'd0, 3'd5: lo_leg = 2'd1;
            3'd1, 3'd2: lo_leg = 2'd2;
            default:    lo_leg = 2'd0;
        endcase
    endfunction

    // ****************************************
    // next state
    // ****************************************
    logic [31:0]      wr_word;
    logic [31:0]      rd_word;
    logic             wr_take;
    logic             accept;
    logic [ST_W-1:0]  events;
    logic [ST_W-1:0]  clr;
    logic             fault_evt;
    logic             commutate;
    logic [CNT_W-1:0] clamped;
    logic [33:0]      align_prod;
    logic [ADC_W-1:0] open_v;
    logic [ADC_W+1:0] bemf;
    logic [ACC_W-1:0] acc_sum;
    logic [1:0]       hl;
    logic [1:0]       ll;

    always_comb begin
        s_next     = s_reg;
        events     = '0;
        clr        = '0;
        commutate  = 1'b0;
        wr_word    = 32'h0000_0000;
        rd_word    = 32'h0000_0000;
        open_v     = '0;
        bemf       = '0;
        acc_sum    = '0;
        fault_evt  = fault_level & ~s_reg.fault_d;
        s_next.fault_d = fault_level;

        // bus slave: one cycle of wait, then a single answer cycle
        accept  = (avs_read | avs_write) & s_reg.waitreq;
        wr_take = avs_write & ~s_reg.waitreq;
        s_next.waitreq = ~accept;

        case (avs_address)
            REG_CTRL:      rd_word = {31'h0, s_reg.run};
            REG_STATUS:    rd_word = {29'h0, s_reg.status};
            REG_MASK:      rd_word = {29'h0, s_reg.mask};
            REG_PERIOD:    rd_word = {16'h0000, s_reg.period};
            REG_DUTY_CMD:  rd_word = {16'h0000, s_reg.duty_cmd};
            REG_CEILING:   rd_word = {16'h0000, s_reg.ceiling};
            REG_FLOOR:     rd_word = {16'h0000, s_reg.floor_lvl};
            REG_FLUX:      rd_word = {8'h00, s_reg.flux};
            REG_OL_TOP:    rd_word = {16'h0000, s_reg.ol_top};
            REG_START_MAX: rd_word = {24'h00_0000, s_reg.start_max};
            REG_STATE:     rd_word = {14'h0000, s_reg.duty[7:0], 1'b0, s_reg.integrating,
                                      fault_level, s_reg.mode, 1'b0, s_reg.step};
            REG_ACC:       rd_word = {8'h00, s_reg.acc};
            default:       rd_word = 32'h0000_0000;
        endcase
        if (accept) begin
            s_next.readdata = avs_read ? rd_word : 32'h0000_0000;
        end

        if (wr_take) begin
            wr_word = merge_be(rd_word, avs_writedata, avs_byteenable);
            case (avs_address)
                REG_CTRL:      s_next.run       = wr_word[CTRL_RUN_BIT];
                REG_STATUS:    clr              = wr_word[ST_W-1:0];
                REG_MASK:      s_next.mask      = wr_word[ST_W-1:0];
                REG_PERIOD:    s_next.period    = wr_word[CNT_W-1:0];
                REG_DUTY_CMD:  s_next.duty_cmd  = wr_word[CNT_W-1:0];
                REG_CEILING:   s_next.ceiling   = wr_word[CNT_W-1:0];
                REG_FLOOR:     s_next.floor_lvl = wr_word[CNT_W-1:0];
                REG_FLUX:      s_next.flux      = wr_word[ACC_W-1:0];
                REG_OL_TOP:    s_next.ol_top    = wr_word[CNT_W-1:0];
                REG_START_MAX: s_next.start_max = wr_word[PCT_W-1:0];
                default:       s_next.run       = s_reg.run;
            endcase
        end

        // ceiling first, floor last: floor wins if set above ceiling
        clamped = s_reg.duty_cmd;
        if (s_reg.duty_cmd > s_reg.ceiling) begin
            clamped = s_reg.ceiling;
        end
        if (clamped < s_reg.floor_lvl) begin
            clamped = s_reg.floor_lvl;
        end
        // percent of period, 655/65536 approximates 1/100 without a divider
        align_prod = 34'(s_reg.period) * 34'(s_reg.align_pct) * 34'd655;

        // back-EMF of the open leg, referenced to half the bus
        case (3'(3) - 3'(hi_leg(s_reg.step)) - 3'(lo_leg(s_reg.step)))
            3'd0:    open_v = adc_phase_a;
            3'd1:    open_v = adc_phase_b;
            default: open_v = adc_phase_c;
        endcase
        bemf = {2'b00, open_v} - {3'b000, adc_bus[ADC_W-1:1]};
        // falling steps see the back-EMF mirrored
        if (!s_reg.step[0]) begin
            bemf = -bemf;
        end

        case (s_reg.mode)
            MODE_IDLE: begin
                if (s_reg.run) begin
                    s_next.mode      = MODE_ALIGN;
                    s_next.step      = 3'd0;
                    s_next.align_pct = START_PCT_RST;
                    s_next.align_cnt = '0;
                end
            end
            MODE_ALIGN: begin
                if (pwm_start) begin
                    s_next.duty = align_prod[31:16];
                    if (s_reg.align_cnt + 16'h0001 >= ALIGN_STEP_PERIODS) begin
                        s_next.align_cnt = '0;
                        if (s_reg.align_pct >= s_reg.start_max) begin
                            s_next.mode        = MODE_OPEN;
                            s_next.ol_interval = OL_START_INTERVAL;
                            s_next.ol_cnt      = '0;
                        end else begin
                            s_next.align_pct = s_reg.align_pct + 8'h01;
                        end
                    end else begin
                        s_next.align_cnt = s_reg.align_cnt + 16'h0001;
                    end
                end
            end
            MODE_OPEN: begin
                if (pwm_start) begin
                    s_next.duty = clamped;
                    if (s_reg.ol_cnt + 16'h0001 >= s_reg.ol_interval) begin
                        commutate     = 1'b1;
                        s_next.ol_cnt = '0;
                        // shrink the step time by a sixteenth per step
                        s_next.ol_interval = s_reg.ol_interval - (s_reg.ol_interval >> 4);
                        if (s_reg.ol_interval <= s_reg.ol_top) begin
                            s_next.mode        = MODE_CLOSED;
                            events[ST_CLOSED]  = 1'b1;
                        end
                    end else begin
                        s_next.ol_cnt = s_reg.ol_cnt + 16'h0001;
                    end
                end
            end
            MODE_CLOSED: begin
                if (pwm_start) begin
                    s_next.duty = clamped;
                end
                if (adc_valid) begin
                    // start only once the open leg has crossed half bus
                    if (!bemf[ADC_W+1] && bemf != '0) begin
                        s_next.integrating = 1'b1;
                    end
                    if (s_reg.integrating && !bemf[ADC_W+1]) begin
                        acc_sum    = s_reg.acc + ACC_W'(bemf);
                        s_next.acc = acc_sum;
                        if (acc_sum >= s_reg.flux) begin
                            commutate = 1'b1;
                        end
                    end
                end
            end
            default: begin
                s_next.mode = MODE_IDLE;
            end
        endcase

        if (commutate) begin
            s_next.step        = (s_reg.step == 3'd5) ? 3'd0 : s_reg.step + 3'd1;
            s_next.acc         = '0;
            s_next.integrating = 1'b0;
            events[ST_COMMUTATE] = 1'b1;
        end

        if (!s_reg.run) begin
            s_next.mode        = MODE_IDLE;
            s_next.acc         = '0;
            s_next.integrating = 1'b0;
            s_next.duty        = '0;
        end

        events[ST_FAULT] = fault_evt;
        // a new event beats a clear landing in the same cycle
        s_next.status = (s_reg.status & ~clr) | events;
        s_next.irq    = |(s_next.status & s_reg.mask);

        // gate drive: edge aligned, no dead time inserted
        hl = hi_leg(s_reg.step);
        ll = lo_leg(s_reg.step);
        s_next.gate_hi = 3'b000;
        s_next.gate_lo = 3'b000;
        if (s_reg.mode != MODE_IDLE && !fault_level) begin
            s_next.gate_hi[hl] = (pwm_count < s_reg.duty);
            s_next.gate_lo[ll] = 1'b1;
        end

        // sample mid on-pulse, once per period
        s_next.sample_req = pwm_tick && (pwm_count == (s_reg.duty >> 1))
                            && s_reg.mode != MODE_IDLE && !fault_level;
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_reg           <= '0;
            s_reg.mode      <= MODE_IDLE;
            s_reg.period    <= PERIOD_RST;
            s_reg.duty_cmd  <= DUTY_CMD_RST;
            s_reg.ceiling   <= CEILING_RST;
            s_reg.floor_lvl <= FLOOR_RST;
            s_reg.flux      <= FLUX_RST;
            s_reg.ol_top    <= OL_TOP_RST;
            s_reg.start_max <= START_MAX_RST;
            s_reg.align_pct <= START_PCT_RST;
            s_reg.waitreq   <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign avs_readdata    = s_reg.readdata;
    assign avs_waitrequest = s_reg.waitreq;
    assign sample_req      = s_reg.sample_req;
    assign gate_hi         = s_reg.gate_hi;
    assign gate_lo         = s_reg.gate_lo;
    assign irq             = s_reg.irq;

endmodule

`default_nettype wire

// >>> core/stc_pkg.sv
package stc_pkg;

    // ****************************************
    // clocking
    // ****************************************
    localparam int unsigned CORE_CLK_HZ     = 100_000_000;
    localparam int unsigned PWM_CLK_HZ      = 25_000_000;
    localparam int unsigned PRESCALE_CYCLES = CORE_CLK_HZ / PWM_CLK_HZ;

    // ****************************************
    // widths
    // ****************************************
    localparam int unsigned CNT_W = 16;
    localparam int unsigned ADC_W = 10;
    localparam int unsigned ACC_W = 24;
    localparam int unsigned PCT_W = 8;

    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_STATUS    = 8'h04;
    localparam logic [7:0] REG_MASK      = 8'h08;
    localparam logic [7:0] REG_PERIOD    = 8'h0C;
    localparam logic [7:0] REG_DUTY_CMD  = 8'h10;
    localparam logic [7:0] REG_CEILING   = 8'h14;
    localparam logic [7:0] REG_FLOOR     = 8'h18;
    localparam logic [7:0] REG_FLUX      = 8'h1C;
    localparam logic [7:0] REG_OL_TOP    = 8'h20;
    localparam logic [7:0] REG_START_MAX = 8'h24;
    localparam logic [7:0] REG_STATE     = 8'h28;
    localparam logic [7:0] REG_ACC       = 8'h2C;

    // ****************************************
    // field positions
    // ****************************************
    localparam int unsigned CTRL_RUN_BIT  = 0;
    localparam int unsigned ST_COMMUTATE  = 0;
    localparam int unsigned ST_FAULT      = 1;
    localparam int unsigned ST_CLOSED     = 2;
    localparam int unsigned ST_W          = 3;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [CNT_W-1:0] PERIOD_RST     = 16'h04E3;
    localparam logic [CNT_W-1:0] CEILING_RST    = 16'h0300;
    localparam logic [CNT_W-1:0] FLOOR_RST      = 16'h0096;
    localparam logic [CNT_W-1:0] DUTY_CMD_RST   = 16'h0000;
    localparam logic [ACC_W-1:0] FLUX_RST       = 24'h00_012C;
    localparam logic [CNT_W-1:0] OL_TOP_RST     = 16'h01DC;
    localparam logic [PCT_W-1:0] START_MAX_RST  = 8'h04;
    localparam logic [PCT_W-1:0] START_PCT_RST  = 8'h01;
    localparam logic [CNT_W-1:0] ALIGN_STEP_RST = 16'h00C8;
    localparam logic [CNT_W-1:0] OL_START_RST   = 16'h07D0;

    // ****************************************
    // drive modes
    // ****************************************
    typedef enum logic [2:0] {
        MODE_IDLE   = 3'b000,
        MODE_ALIGN  = 3'b001,
        MODE_OPEN   = 3'b010,
        MODE_CLOSED = 3'b011
    } stc_mode_t;

endpackage

// >>> core/stc_sync3.sv
`timescale 1ns/100ps
`default_nettype none

module stc_sync3
    import stc_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic pin_in,
    output logic      level_out
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } stc_sync_t;

    stc_sync_t s_reg;
    stc_sync_t s_next;

    always_comb begin
        s_next    = s_reg;
        s_next.s1 = pin_in;
        s_next.s2 = s_reg.s1;
        s_next.s3 = s_reg.s2;
        // a change counts only once two settled stages agree
        if (s_reg.s2 == s_reg.s3) begin
            s_next.level = s_reg.s3;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign level_out = s_reg.level;

endmodule

`default_nettype wire

// >>> core/stc_pwm_timer.sv
`timescale 1ns/100ps
`default_nettype none

module stc_pwm_timer
    import stc_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic [CNT_W-1:0] period,
    output logic      [CNT_W-1:0] count,
    output logic                  tick,
    output logic                  period_start
);

    localparam logic [7:0] PRE_LAST = 8'(PRESCALE_CYCLES - 1);

    typedef struct packed {
        logic [7:0]       pre;
        logic [CNT_W-1:0] cnt;
        logic             tick;
        logic             start;
    } stc_tmr_t;

    stc_tmr_t s_reg;
    stc_tmr_t s_next;

    always_comb begin
        s_next       = s_reg;
        s_next.tick  = 1'b0;
        s_next.start = 1'b0;
        // 25 MHz count rate derived from the core clock
        if (s_reg.pre == PRE_LAST) begin
            s_next.pre  = 8'h00;
            s_next.tick = 1'b1;
            // up mode: period value minus one ticks, so 1251 gives exactly 20 kHz
            if (s_reg.cnt + 16'h0002 >= period) begin
                s_next.cnt   = '0;
                s_next.start = 1'b1;
            end else begin
                s_next.cnt = s_reg.cnt + 16'h0001;
            end
        end else begin
            s_next.pre = s_reg.pre + 8'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign count        = s_reg.cnt;
    assign tick         = s_reg.tick;
    assign period_start = s_reg.start;

endmodule

`default_nettype wire

// >>> test/stc_chk.sv
`timescale 1ns/100ps
`default_nettype none
module stc_chk (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       avs_read,
    input wire logic       avs_write,
    input wire logic       avs_waitrequest,
    input wire logic       overcurrent_fault_input,
    input wire logic       sample_req,
    input wire logic [2:0] gate_hi,
    input wire logic [2:0] gate_lo
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ********
    // gates and bus
    // ********
    no_shoot_a: assert property ((gate_hi & gate_lo) == 3'h0)
        else $error("leg driven both ways");
    two_legs_a: assert property (
        gate_hi != 3'h0 |-> $onehot(gate_hi) && $onehot(gate_lo))
        else $error("chop without one low leg");
    one_low_a: assert property ($onehot0(gate_lo))
        else $error("two low sides on");
    fault_off_a: assert property (
        overcurrent_fault_input [*6] |=> (gate_hi | gate_lo) == 3'h0)
        else $error("gates on during fault");
    reset_off_a: assert property (!$past(rst_n) |-> (gate_hi | gate_lo) == 3'h0)
        else $error("gates on after reset");
    once_per_a: assert property (sample_req |=> !sample_req [*8])
        else $error("sample request too soon");
    wait_ans_a: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("bus answer too long");
    fault_c: cover property (overcurrent_fault_input [*4]);
    samp_c: cover property (sample_req);
    comm_c: cover property (gate_hi != 3'h0 && $changed(gate_lo));
endmodule
bind stc_commutator stc_chk u_chk (
    .core_clk (core_clk), .rst_n (rst_n), .avs_read (avs_read), .avs_write (avs_write),
    .avs_waitrequest (avs_waitrequest), .overcurrent_fault_input (overcurrent_fault_input),
    .sample_req (sample_req), .gate_hi (gate_hi), .gate_lo (gate_lo)
);
`default_nettype wire

// >>> test/stc_stage_model.sv
`timescale 1ns/100ps
`default_nettype none
module stc_stage_model
    import stc_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic [2:0]       gate_hi,
    input  wire logic [2:0]       gate_lo,
    input  wire logic             sample_req,
    output logic      [ADC_W-1:0] adc_phase_a,
    output logic      [ADC_W-1:0] adc_phase_b,
    output logic      [ADC_W-1:0] adc_phase_c,
    output logic      [ADC_W-1:0] adc_bus,
    output logic                  adc_valid
);
    // ********
    // phase sensing
    // ********
    logic [ADC_W-1:0] ph [3] = '{10'h000, 10'h000, 10'h000};
    logic             even;
    logic [ADC_W-1:0] v_open;
    // low leg one after the high leg marks an even step, whose rise shows as a fall
    assign even   = (gate_lo == {gate_hi[1:0], gate_hi[2]});
    assign v_open = even ? 10'h0d8 : 10'h128;
    initial adc_valid = 1'b0;
    initial adc_bus = 10'h000;
    always @(posedge core_clk) begin
        adc_valid <= sample_req;
        // between samples the lines toggle so stale data is never mistaken for valid
        adc_bus <= sample_req ? 10'h200 : ~adc_bus;
        for (int i = 0; i < 3; i++) begin
            if (sample_req) begin
                ph[i] <= gate_hi[i] ? 10'h200 : (gate_lo[i] ? 10'h000 : v_open);
            end else begin
                ph[i] <= ~ph[i];
            end
        end
    end
    assign adc_phase_a = ph[0];
    assign adc_phase_b = ph[1];
    assign adc_phase_c = ph[2];
endmodule
`default_nettype wire

// >>> test/sensorless_trapezoidal_commutation_bench.sv
`timescale 1ns/100ps
`default_nettype none
module sensorless_trapezoidal_commutation_bench;
    import stc_pkg::*;
    typedef struct packed {
        logic [1:0]  k;
        logic [7:0]  a;
        logic [31:0] v;
    } stc_row_t;
    // k: 0 read only, 1 write and read back, 2 write ignored
    localparam stc_row_t ROWS [20] = '{
        '{2'd0, REG_PERIOD, 32'h0000_04e3}, '{2'd0, REG_CEILING, 32'h0000_0300},
        '{2'd0, REG_FLOOR, 32'h0000_0096}, '{2'd0, REG_FLUX, 32'h0000_012c},
        '{2'd0, REG_OL_TOP, 32'h0000_01dc}, '{2'd0, REG_START_MAX, 32'h0000_0004},
        '{2'd0, REG_CTRL, 32'h0000_0000}, '{2'd0, REG_STATUS, 32'h0000_0000},
        '{2'd0, REG_MASK, 32'h0000_0000}, '{2'd0, REG_STATE, 32'h0000_0000},
        '{2'd0, REG_ACC, 32'h0000_0000}, '{2'd0, REG_DUTY_CMD, 32'h0000_0000},
        '{2'd1, REG_PERIOD, 32'h0000_0014}, '{2'd1, REG_CEILING, 32'h0000_000c},
        '{2'd1, REG_FLOOR, 32'h0000_0003}, '{2'd1, REG_FLUX, 32'h0000_00c8},
        '{2'd1, REG_OL_TOP, 32'h0000_0010}, '{2'd1, REG_DUTY_CMD, 32'h0000_0064},
        '{2'd2, REG_ACC, 32'h0000_00ff}, '{2'd2, 8'h3c, 32'h0000_00ff}};
    logic             core_clk = 1'b0;
    logic             rst_n = 1'b0;
    logic [7:0]       avs_address = 8'h00;
    logic             avs_read = 1'b0;
    logic             avs_write = 1'b0;
    logic [31:0]      avs_writedata = 32'h0000_0000;
    logic [31:0]      avs_readdata;
    logic             avs_waitrequest;
    logic             fault = 1'b0;
    logic [ADC_W-1:0] adc_a, adc_b, adc_c, adc_bus;
    logic             adc_valid, sample_req, irq;
    logic [2:0]       gate_hi, gate_lo;
    logic [5:0]       last = 6'h00;
    logic [31:0]      rd;
    logic [5:0]       pat [6] = '{6'h0a, 6'h0c, 6'h14, 6'h11, 6'h21, 6'h22};
    int               err_count = 0, n_tests = 0, ncomm = 0, nsamp = 0, gap = 0;
    int               hcnt = 0, hlast = 0, pcnt = 0, plast = 0;
    always #5 core_clk = ~core_clk;
    stc_commutator #(.ALIGN_STEP_PERIODS (16'h0002), .OL_START_INTERVAL (16'h0014)) DUT (
        .core_clk (core_clk), .rst_n (rst_n), .avs_address (avs_address),
        .avs_read (avs_read), .avs_write (avs_write), .avs_writedata (avs_writedata),
        .avs_byteenable (4'hf), .avs_readdata (avs_readdata), .avs_waitrequest (avs_waitrequest),
        .overcurrent_fault_input (fault), .adc_phase_a (adc_a), .adc_phase_b (adc_b),
        .adc_phase_c (adc_c), .adc_bus (adc_bus), .adc_valid (adc_valid),
        .sample_req (sample_req), .gate_hi (gate_hi), .gate_lo (gate_lo), .irq (irq));
    stc_stage_model u_stage (
        .core_clk (core_clk), .gate_hi (gate_hi), .gate_lo (gate_lo), .sample_req (sample_req),
        .adc_phase_a (adc_a), .adc_phase_b (adc_b), .adc_phase_c (adc_c), .adc_bus (adc_bus),
        .adc_valid (adc_valid));
    task chk(string nm, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task bus(logic w, logic [7:0] a, logic [31:0] wd);
        int k;
        @(posedge core_clk);
        avs_address   <= a;
        avs_writedata <= wd;
        avs_read      <= !w;
        avs_write     <= w;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (avs_waitrequest !== 1'b0);
        chk("bus wait", 32'h0000_0002, k);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task wait_comm(int n);
        int c0;
        c0 = ncomm;
        for (int k = 0; k < 30000 && ncomm < c0 + n; k++) @(posedge core_clk);
        chk("commutations", 32'h1, {31'h0, ncomm >= c0 + n});
    endtask
    // ********
    // gate monitor: step order, gap, duty, period
    // ********
    always @(posedge core_clk) begin
        if (!rst_n) last = 6'h00;
        hcnt = hcnt + (gate_hi != 3'h0);
        pcnt++;
        if (sample_req === 1'b1) begin
            nsamp++;
            hlast = hcnt;
            plast = pcnt;
            hcnt = 0;
            pcnt = 0;
        end
        if (rst_n && gate_hi != 3'h0 && {gate_hi, gate_lo} !== last) begin
            chk("step", last == 6'h00 ? pat[0] : pat[(idx(last) + 1) % 6], {gate_hi, gate_lo});
            last = {gate_hi, gate_lo};
            ncomm++;
            gap = nsamp;
            nsamp = 0;
        end
    end
    function int idx(logic [5:0] p);
        for (int i = 0; i < 6; i++) if (pat[i] === p) return i;
        return 6;
    endfunction
    initial begin
        repeat (90000) @(posedge core_clk);
        err_count++;
        finish_test();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (ROWS[i]) begin
            if (ROWS[i].k != 2'd0) bus(1'b1, ROWS[i].a, ROWS[i].v);
            bus(1'b0, ROWS[i].a, 32'h0);
            chk("register", ROWS[i].k == 2'd2 ? 32'h0 : ROWS[i].v, rd);
        end
        bus(1'b1, REG_MASK, 32'h0000_0004);
        bus(1'b1, REG_CTRL, 32'h0000_0001);
        for (int k = 0; k < 30000 && irq !== 1'b1; k++) @(posedge core_clk);
        bus(1'b0, REG_STATUS, 32'h0);
        chk("closed loop", 32'h4, rd & 32'h4);
        repeat (240) @(posedge core_clk);
        chk("high time", 32'd48, hlast);
        chk("period", 32'h0000_004c, plast);
        wait_comm(2);
        chk("flux gap", 32'h0000_0006, gap);
        bus(1'b1, REG_FLUX, 32'h0000_0190);
        wait_comm(2);
        chk("flux gap", 32'h0000_000b, gap);
        bus(1'b1, REG_DUTY_CMD, 32'h0000_0001);
        repeat (240) @(posedge core_clk);
        chk("floor time", 32'd12, hlast);
        bus(1'b1, REG_STATUS, 32'h0000_0004);
        bus(1'b0, REG_STATUS, 32'h0);
        chk("status clear", 32'h0, rd & 32'h4);
        chk("irq low", 32'h0, {31'h0, irq});
        fault <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk("fault gates", 32'h0, {26'h0, gate_hi, gate_lo});
        bus(1'b1, REG_MASK, 32'h0000_0002);
        repeat (2) @(posedge core_clk);
        chk("fault irq", 32'h1, {31'h0, irq});
        fault <= 1'b0;
        bus(1'b1, REG_MASK, 32'h0000_0000);
        repeat (240) @(posedge core_clk);
        chk("masked irq", 32'h0, {31'h0, irq});
        chk("resume time", 32'd12, hlast);
        rst_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk("reset gates", 32'h0, {26'h0, gate_hi, gate_lo});
        rst_n <= 1'b1;
        bus(1'b0, REG_STATE, 32'h0);
        chk("reset state", 32'h0, rd);
        bus(1'b0, REG_ACC, 32'h0);
        chk("reset acc", 32'h0, rd);
        finish_test();
    end
endmodule
`default_nettype wire
